// ==== logic/ethernet_flow_matcher.sv ====
// Overview of operation
// - No backbone: tag1 type 0 is 0x8100 tag, 1 matches global identifier.
// - Backbone: tag1 type 0 global-identifier tag, 1 I-tag; type 0 needs two tags, type 1 at least one.
// - No backbone: tag2 type 0 is 0x8100 tag, 1 matches global identifier.
// - Backbone: second tag is always an I-tag; tag2 type ignored.
// - Format bit 0: only Ethertype frames, no LLC/SNAP allowed.
// - Format bit 1: type below 0x0600 needs LLC/SNAP, otherwise none allowed.
// - Verify 0: only tag count and range limits checked; backbone I-tag still checked.
// - Verify 1: tag count and tag values all checked.
// - Range mode 0 none, 1 first tag, 2 second tag.
// - Each flow compares a 48-bit address value to the selected frame address.
// - Select 0 destination, 1 source, 2 either; 3 reserved.
// - Kind bits combine: full address, any unicast, any multicast.
// - Unicast or multicast judged by address MSB alone.
// - First tag identifier compared to its match value under mask.
// - Second tag identifier compared to its match value under mask.
// - Without backbone, range limits bound the tag chosen by range mode.
// - With backbone, limits form upper and lower halves of the I-tag id.
// - OAM engine: per-flow group bit picks next-protocol set A or B.
// - OAM engine: two sets share at most eight flows.
// - Flow applies only to channels whose mask bit is set.
// - Two-bit expected tag count: zero, one or two.
// - One global backbone-bridging enable bit.
module ethernet_flow_matcher
  import flow_match_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  input  wire hdr_s        hdr_in,
  output result_s          result_out
);
`include "flow_match_cfg.svh"

  typedef struct packed {
    flow_cfg_s [`NUM_FLOWS-1:0] flow;
    logic                       backbone_bridging_enable;
    logic                       oam_engine;
    logic [15:0]                global_tag_identifier;
    logic [31:0]                rdata;
    result_s                    result;
    logic [7:0]                 last_matched;
  } state_s;

  state_s state_reg;
  state_s state_next;

  // Tag header check for one tag slot given its configured type
  function automatic logic tpid_ok(input logic ttype, input logic [15:0] tpid, input logic [15:0] gid);
    tpid_ok = ttype ? (tpid == gid) : (tpid == `CTAG_ID);
  endfunction : tpid_ok

  function automatic logic in_range(input logic [11:0] v, input logic [11:0] lo, input logic [11:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  function automatic logic addr_ok(input logic [2:0] kind, input logic [47:0] val, input logic [47:0] a);
    addr_ok = (kind[0] && (a == val))
           || (kind[1] && !a[47])
           || (kind[2] && a[47]);
  endfunction : addr_ok

  // Per-flow match evaluation
  logic [`NUM_FLOWS-1:0] hit;
  genvar g;
  generate
    for (g = 0; g < `NUM_FLOWS; g++)
    begin : g_flow
      flow_cfg_s c;
      logic fmt_ok;
      logic count_ok;
      logic val_ok;
      logic rng_ok;
      logic adr_ok;
      logic is_len;
      assign c = state_reg.flow[g];
      assign is_len = hdr_in.type_len < `LEN_LIMIT;
      always_comb
      begin
        if (!c.frame_format_mode)
          fmt_ok = !hdr_in.llc_snap_seen && !is_len;
        else
          fmt_ok = is_len ? hdr_in.llc_snap_seen : !hdr_in.llc_snap_seen;
        val_ok = 1'b1;
        rng_ok = 1'b1;
        if (state_reg.backbone_bridging_enable)
        begin
          // Two tags: global-id tag then I-tag, or I-tag as first with at least one tag seen
          count_ok = c.first_tag_type ? (hdr_in.tags_seen != 2'h0) : (hdr_in.tags_seen == 2'h2);
          if (!c.first_tag_type && c.tag_verify_enable)
            val_ok = tpid_ok(1'b1, hdr_in.tag1_tpid, state_reg.global_tag_identifier)
                  && ((hdr_in.tag1_vid & c.first_tag_bitmask) ==
                      (c.first_tag_compare & c.first_tag_bitmask));
          // I-tag always checked
          val_ok = val_ok && (hdr_in.itag_sid == {c.tag_range_high, c.tag_range_low});
        end
        else
        begin
          count_ok = hdr_in.tags_seen == c.tag_count;
          if (c.tag_verify_enable)
          begin
            if (c.tag_count != 2'h0)
              val_ok = tpid_ok(c.first_tag_type, hdr_in.tag1_tpid, state_reg.global_tag_identifier)
                    && ((hdr_in.tag1_vid & c.first_tag_bitmask) ==
                        (c.first_tag_compare & c.first_tag_bitmask));
            if (c.tag_count == 2'h2)
              val_ok = val_ok
                    && tpid_ok(c.second_tag_type, hdr_in.tag2_tpid, state_reg.global_tag_identifier)
                    && ((hdr_in.tag2_vid & c.second_tag_bitmask) ==
                        (c.second_tag_compare & c.second_tag_bitmask));
          end
          if (c.tag_range_mode == 2'h1)
            rng_ok = in_range(hdr_in.tag1_vid, c.tag_range_low, c.tag_range_high);
          else if (c.tag_range_mode == 2'h2)
            rng_ok = in_range(hdr_in.tag2_vid, c.tag_range_low, c.tag_range_high);
        end
        case (c.station_field_select)
          SEL_DEST:   adr_ok = addr_ok(c.station_compare_kind, c.station_compare_value, hdr_in.dest_addr);
          SEL_SRC:    adr_ok = addr_ok(c.station_compare_kind, c.station_compare_value, hdr_in.src_addr);
          SEL_EITHER: adr_ok = addr_ok(c.station_compare_kind, c.station_compare_value, hdr_in.dest_addr)
                            || addr_ok(c.station_compare_kind, c.station_compare_value, hdr_in.src_addr);
          default:    adr_ok = 1'b0;
        endcase
      end
      assign hit[g] = c.enable && c.chan_mask[hdr_in.channel] && fmt_ok && count_ok && val_ok && rng_ok && adr_ok;
    end
  endgenerate

  logic [7:0] group_b_vec;
  generate
    for (g = 0; g < `NUM_FLOWS; g++)
    begin : g_grp
      // Group bit is meaningless outside the OAM engine
      assign group_b_vec[g] = state_reg.oam_engine && state_reg.flow[g].flow_group_select;
    end
  endgenerate

  function automatic logic [31:0] flow_word(input flow_cfg_s c, input logic [1:0] w);
    case (w)
      2'h0: flow_word = {13'h0, c.flow_group_select, c.station_compare_kind, c.station_field_select,
                         c.tag_range_mode, c.tag_verify_enable, c.frame_format_mode, c.second_tag_type,
                         c.first_tag_type, c.tag_count, c.chan_mask, c.enable};
      2'h1: flow_word = c.station_compare_value[31:0];
      2'h2: flow_word = {c.first_tag_bitmask, c.first_tag_compare, c.station_compare_value[47:40]};
      default: flow_word = {c.second_tag_bitmask, c.second_tag_compare, 8'h0};
    endcase
  endfunction : flow_word

  logic [7:0] frel;
  assign frel = reg_addr - `ADDR_FLOW_BASE;

  always_comb
  begin
    state_next = state_reg;
    state_next.rdata = 32'h0;
    state_next.result.valid = hdr_in.valid;
    state_next.result.matched = hdr_in.valid ? hit : 8'h0;
    state_next.result.group_b = group_b_vec;
    if (hdr_in.valid)
      state_next.last_matched = hit;
    if (reg_write)
    begin
      if (reg_addr == `ADDR_GLOBAL)
      begin
        state_next.backbone_bridging_enable = reg_wdata[`G_BACKBONE];
        state_next.oam_engine = reg_wdata[`G_OAM];
      end
      else if (reg_addr == `ADDR_TPID)
        state_next.global_tag_identifier = reg_wdata[15:0];
      else if (reg_addr >= `ADDR_FLOW_BASE && frel < 8'h20)
      begin
        case (frel[1:0])
          2'h0:
          begin
            state_next.flow[frel[4:2]].enable = reg_wdata[`F0_ENABLE];
            state_next.flow[frel[4:2]].chan_mask = reg_wdata[`F0_CHAN_LSB +: 4];
            state_next.flow[frel[4:2]].tag_count = reg_wdata[`F0_TCOUNT_LSB +: 2];
            state_next.flow[frel[4:2]].first_tag_type = reg_wdata[`F0_T1TYPE];
            state_next.flow[frel[4:2]].second_tag_type = reg_wdata[`F0_T2TYPE];
            state_next.flow[frel[4:2]].frame_format_mode = reg_wdata[`F0_FMT];
            state_next.flow[frel[4:2]].tag_verify_enable = reg_wdata[`F0_VERIFY];
            state_next.flow[frel[4:2]].tag_range_mode = reg_wdata[`F0_RMODE_LSB +: 2];
            state_next.flow[frel[4:2]].station_field_select = station_field_select_e'(reg_wdata[`F0_SEL_LSB +: 2]);
            state_next.flow[frel[4:2]].station_compare_kind = reg_wdata[`F0_KIND_LSB +: 3];
            state_next.flow[frel[4:2]].flow_group_select = reg_wdata[`F0_GROUP];
          end
          2'h1: state_next.flow[frel[4:2]].station_compare_value[31:0] = reg_wdata;
          2'h2:
          begin
            state_next.flow[frel[4:2]].station_compare_value[47:32] = reg_wdata[15:0];
            state_next.flow[frel[4:2]].first_tag_compare = reg_wdata[27:16];
          end
          default:
          begin
            state_next.flow[frel[4:2]].first_tag_bitmask = reg_wdata[11:0];
            state_next.flow[frel[4:2]].second_tag_compare = reg_wdata[23:12];
          end
        endcase
      end
    end
    if (reg_read)
    begin
      if (reg_addr == `ADDR_GLOBAL)
        state_next.rdata = {30'h0, state_reg.oam_engine, state_reg.backbone_bridging_enable};
      else if (reg_addr == `ADDR_TPID)
        state_next.rdata = {16'h0, state_reg.global_tag_identifier};
      else if (reg_addr == `ADDR_MATCHED)
        state_next.rdata = {24'h0, state_reg.last_matched};
      else if (reg_addr >= `ADDR_FLOW_BASE && frel < 8'h20)
        state_next.rdata = rd_word(state_reg.flow[frel[4:2]], frel[1:0]);
    end
  end

  // Packing for reads, kept in register-write layout
  function automatic logic [31:0] rd_word(input flow_cfg_s c, input logic [1:0] w);
    case (w)
      2'h0: rd_word = {13'h0, c.flow_group_select, c.station_compare_kind, c.station_field_select,
                       c.tag_range_mode, c.tag_verify_enable, c.frame_format_mode, c.second_tag_type,
                       c.first_tag_type, c.tag_count, c.chan_mask, c.enable};
      2'h1: rd_word = c.station_compare_value[31:0];
      2'h2: rd_word = {4'h0, c.first_tag_compare, c.station_compare_value[47:32]};
      default: rd_word = {8'h0, c.second_tag_compare, c.first_tag_bitmask};
    endcase
  endfunction : rd_word

  // Remaining per-flow fields: second mask and range limits, at extra words
  logic [7:0] xrel;
  assign xrel = reg_addr - 8'h40;
  state_s state_fix;
  always_comb
  begin
    state_fix = state_next;
    if (reg_write && reg_addr >= 8'h40 && xrel < 8'h10)
    begin
      if (!xrel[0])
        state_fix.flow[xrel[3:1]].second_tag_bitmask = reg_wdata[11:0];
      else
      begin
        state_fix.flow[xrel[3:1]].tag_range_low = reg_wdata[11:0];
        state_fix.flow[xrel[3:1]].tag_range_high = reg_wdata[23:12];
      end
    end
    if (reg_read && reg_addr >= 8'h40 && xrel < 8'h10)
      state_fix.rdata = xrel[0] ? {8'h0, state_reg.flow[xrel[3:1]].tag_range_high,
                                   state_reg.flow[xrel[3:1]].tag_range_low}
                                : {20'h0, state_reg.flow[xrel[3:1]].second_tag_bitmask};
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= '0;
      state_reg.global_tag_identifier <= `TPID_RESET;
    end
    else
      state_reg <= state_fix;
  end

  assign reg_rdata = state_reg.rdata;
  assign result_out = state_reg.result;

  a_result_timing: assert property (@(posedge clk) disable iff (!nrst)
    hdr_in.valid |=> result_out.valid && (result_out.matched == $past(hit)))
    else $error("result not one cycle after header");
  a_disabled_silent: assert property (@(posedge clk) disable iff (!nrst)
    (hdr_in.valid && !state_reg.flow[0].enable) |=> !result_out.matched[0])
    else $error("disabled flow matched");
  a_chan_mask_gate: assert property (@(posedge clk) disable iff (!nrst)
    (hdr_in.valid && !state_reg.flow[0].chan_mask[hdr_in.channel]) |=> !result_out.matched[0])
    else $error("flow matched on masked channel");
  a_reserved_select: assert property (@(posedge clk) disable iff (!nrst)
    (hdr_in.valid && state_reg.flow[0].station_field_select == SEL_RSVD) |=> !result_out.matched[0])
    else $error("reserved select matched");
  a_itag_checked: assert property (@(posedge clk) disable iff (!nrst)
    (hdr_in.valid && state_reg.backbone_bridging_enable
     && hdr_in.itag_sid != {state_reg.flow[0].tag_range_high, state_reg.flow[0].tag_range_low})
    |=> !result_out.matched[0])
    else $error("I-tag mismatch matched");
  a_format_strict: assert property (@(posedge clk) disable iff (!nrst)
    (hdr_in.valid && !state_reg.flow[0].frame_format_mode && hdr_in.llc_snap_seen) |=> !result_out.matched[0])
    else $error("LLC frame matched in Ethertype mode");
  a_range_first: assert property (@(posedge clk) disable iff (!nrst)
    (hdr_in.valid && !state_reg.backbone_bridging_enable && state_reg.flow[0].tag_range_mode == 2'h1
     && hdr_in.tag1_vid > state_reg.flow[0].tag_range_high) |=> !result_out.matched[0])
    else $error("out-of-range tag matched");
  a_count_exact: assert property (@(posedge clk) disable iff (!nrst)
    (hdr_in.valid && !state_reg.backbone_bridging_enable && hdr_in.tags_seen != state_reg.flow[0].tag_count)
    |=> !result_out.matched[0])
    else $error("wrong tag count matched");
  a_group_oam: assert property (@(posedge clk) disable iff (!nrst)
    !state_reg.oam_engine |=> result_out.group_b == 8'h0)
    else $error("group B outside OAM engine");
  a_read_latency: assert property (@(posedge clk) disable iff (!nrst)
    (reg_read && reg_addr == `ADDR_TPID) |=> reg_rdata == {16'h0, $past(state_reg.global_tag_identifier)})
    else $error("read data wrong");

  c_any_match:      cover property (@(posedge clk) disable iff (!nrst) result_out.valid && result_out.matched != 8'h0);
  c_backbone_match: cover property (@(posedge clk) disable iff (!nrst)
    state_reg.backbone_bridging_enable && result_out.matched != 8'h0);
  c_snap_match:     cover property (@(posedge clk) disable iff (!nrst)
    hdr_in.valid && hdr_in.llc_snap_seen && hit != 8'h0);
  c_group_split:    cover property (@(posedge clk) disable iff (!nrst)
    result_out.group_b != 8'h0 && result_out.group_b != 8'hff);
endmodule : ethernet_flow_matcher

// ==== logic/flow_match_cfg.svh ====
`ifndef FLOW_MATCH_CFG_SVH
`define FLOW_MATCH_CFG_SVH
// Register map, word addresses on the plain register port
`define ADDR_GLOBAL      8'h00
`define ADDR_TPID        8'h01
`define ADDR_MATCHED     8'h02
`define ADDR_FLOW_BASE   8'h10
`define FLOW_STRIDE      3'h4
// Flow word 0 fields
`define F0_ENABLE        0
`define F0_CHAN_LSB      1
`define F0_TCOUNT_LSB    5
`define F0_T1TYPE        7
`define F0_T2TYPE        8
`define F0_FMT           9
`define F0_VERIFY        10
`define F0_RMODE_LSB     11
`define F0_SEL_LSB       13
`define F0_KIND_LSB      15
`define F0_GROUP         18
// Global word fields
`define G_BACKBONE       0
`define G_OAM            1
// Constants
`define CTAG_ID          16'h8100
`define LEN_LIMIT        16'h0600
`define TPID_RESET       16'h88a8
`define NUM_FLOWS        8
`define NUM_CHAN         4
`endif

// ==== logic/flow_match_pkg.sv ====
package flow_match_pkg;
  typedef enum logic [1:0] {
    SEL_DEST   = 2'h0,
    SEL_SRC    = 2'h1,
    SEL_EITHER = 2'h2,
    SEL_RSVD   = 2'h3
  } station_field_select_e;

  // Per-flow configuration
  typedef struct packed {
    logic                  enable;
    logic [3:0]            chan_mask;
    logic [1:0]            tag_count;
    logic                  first_tag_type;
    logic                  second_tag_type;
    logic                  frame_format_mode;
    logic                  tag_verify_enable;
    logic [1:0]            tag_range_mode;
    station_field_select_e station_field_select;
    logic [2:0]            station_compare_kind;
    logic                  flow_group_select;
    logic [47:0]           station_compare_value;
    logic [11:0]           first_tag_compare;
    logic [11:0]           first_tag_bitmask;
    logic [11:0]           second_tag_compare;
    logic [11:0]           second_tag_bitmask;
    logic [11:0]           tag_range_high;
    logic [11:0]           tag_range_low;
  } flow_cfg_s;

  // Parsed header from the frame pipeline
  typedef struct packed {
    logic        valid;
    logic [1:0]  channel;
    logic [47:0] dest_addr;
    logic [47:0] src_addr;
    logic [1:0]  tags_seen;
    logic [15:0] tag1_tpid;
    logic [11:0] tag1_vid;
    logic [15:0] tag2_tpid;
    logic [11:0] tag2_vid;
    logic [23:0] itag_sid;
    logic [15:0] type_len;
    logic        llc_snap_seen;
  } hdr_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] matched;
    logic [7:0] group_b;
  } result_s;
endpackage : flow_match_pkg

// ==== verif/header_feeder.sv ====
module header_feeder
  import flow_match_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire hdr_s req,
  input  wire logic send,
  output hdr_s      hdr_out
);
  timeunit 1ns;
  timeprecision 1ps;

  hdr_s last_reg;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      last_reg <= '0;
    else if (send)
      last_reg <= req;

  // Idle fields show the inverse of the last header, so stale data cannot match by luck
  always_comb
  begin
    hdr_out       = send ? req : ~last_reg;
    hdr_out.valid = send;
  end
endmodule : header_feeder

// ==== verif/ethernet_flow_matcher_tb_top.sv ====
`include "flow_match_cfg.svh"
module ethernet_flow_matcher_tb_top
  import flow_match_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [47:0] addr_a = 48'h0123_4567_89ab;
  localparam logic [47:0] addr_b = 48'h8abc_def0_1234;
  logic        clk       = 1'b0;
  logic        nrst      = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_write = 1'b0;
  logic        reg_read  = 1'b0;
  logic [31:0] reg_rdata;
  logic        send      = 1'b0;
  hdr_s        req       = '0;
  hdr_s        hdr_in;
  hdr_s        h;
  result_s     result_out;
  int          error_cnt = 0;
  int          tests_run = 0;
  // Format cases: {format bit, llc seen, expected hit, type/length}
  logic [18:0] ft [0:6] = '{19'h10800, 19'h20800, 19'h005ff, 19'h705ff, 19'h405ff, 19'h50600, 19'h60600};

  always #12.5 clk = ~clk;

  header_feeder feeder (.clk(clk), .nrst(nrst), .req(req), .send(send), .hdr_out(hdr_in));

  ethernet_flow_matcher dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .hdr_in(hdr_in),
    .result_out(result_out));

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask : rd

  // b4 packs {verify, format, tag2 type, tag1 type}
  function automatic logic [31:0] w0f(input logic [3:0] ch, input logic [1:0] tc, input logic [3:0] b4,
                                      input logic [1:0] rm, input logic [1:0] sl, input logic [2:0] kd);
    return {14'h0, kd, sl, rm, b4, tc, ch, 1'b1};
  endfunction : w0f

  // t packs {tag1 cmp, tag1 mask, tag2 cmp, tag2 mask, low, high}; unused masks stay zero
  task automatic cfg(input logic [31:0] w0, input logic [71:0] t);
    wr(`ADDR_FLOW_BASE, w0);
    wr(8'h11, addr_a[31:0]);
    wr(8'h12, {4'h0, t[71:60], addr_a[47:32]});
    wr(8'h13, {8'h0, t[47:36], t[59:48]});
    wr(8'h40, {20'h0, t[35:24]});
    wr(8'h41, {8'h0, t[11:0], t[23:12]});
  endtask : cfg

  task automatic hbase;
    h           = '0;
    h.dest_addr = addr_a;
    h.src_addr  = addr_b;
    h.type_len  = 16'h0800;
  endtask : hbase

  task automatic go(input logic [7:0] exp);
    int i;
    @(posedge clk);
    req  <= h;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    i = 0;
    do
    begin
      @(negedge clk);
      i++;
    end while (result_out.valid !== 1'b1 && i < 4);
    if (result_out.valid !== 1'b1)
    begin
      error_cnt++;
      wrap_up();
    end
    else
      chk({24'h0, result_out.matched}, {24'h0, exp});
  endtask : go

  initial
  begin
    int s;
    int k;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(`ADDR_TPID, 32'h0000_88a8);
    rd(`ADDR_GLOBAL, 32'h0);
    rd(`ADDR_MATCHED, 32'h0);
    wr(8'h3f, 32'hffff_ffff);
    rd(8'h3f, 32'h0);
    wr(`ADDR_FLOW_BASE, 32'h0007_ffff);
    rd(`ADDR_FLOW_BASE, 32'h0007_ffff);
    $display("test registers done");
    hbase();
    for (s = 0; s < 4; s++)
    begin
      cfg(w0f(4'h1, 2'h0, 4'h0, 2'h0, s[1:0], 3'h1), 72'h0);
      h.dest_addr = addr_a;
      h.src_addr  = addr_b;
      go({7'h0, s == 0 || s == 2});
      h.dest_addr = addr_b;
      h.src_addr  = addr_a;
      go({7'h0, s == 1 || s == 2});
    end
    cfg(w0f(4'h2, 2'h0, 4'h0, 2'h0, 2'h0, 3'h1), 72'h0);
    hbase();
    go(8'h00);
    h.channel = 2'h1;
    go(8'h01);
    h.dest_addr = addr_a ^ 48'h1;
    go(8'h00);
    wr(`ADDR_FLOW_BASE, w0f(4'h2, 2'h0, 4'h0, 2'h0, 2'h0, 3'h1) & 32'hffff_fffe);
    h.dest_addr = addr_a;
    go(8'h00);
    $display("test address select done");
    for (k = 1; k < 8; k++)
    begin
      cfg(w0f(4'h1, 2'h0, 4'h0, 2'h0, 2'h0, k[2:0]), 72'h0);
      hbase();
      go({7'h0, k[0] | k[1]});
      h.dest_addr = addr_a ^ 48'h1;
      go({7'h0, k[1]});
      h.dest_addr = {1'b1, addr_a[46:0]};
      go({7'h0, k[2]});
    end
    $display("test address kind done");
    for (k = 0; k < 7; k++)
    begin
      cfg(w0f(4'h1, 2'h0, {1'b0, ft[k][18], 2'h0}, 2'h0, 2'h0, 3'h1), 72'h0);
      hbase();
      h.llc_snap_seen = ft[k][17];
      h.type_len      = ft[k][15:0];
      go({7'h0, ft[k][16]});
    end
    $display("test frame format done");
    cfg(w0f(4'h1, 2'h1, 4'h8, 2'h0, 2'h0, 3'h1), {24'h123ff0, 48'h0});
    hbase();
    h.tags_seen = 2'h1;
    h.tag1_tpid = 16'h8100;
    h.tag1_vid  = 12'h12f;
    go(8'h01);
    h.tag1_vid = 12'h133;
    go(8'h00);
    h.tag1_vid  = 12'h123;
    h.tags_seen = 2'h2;
    go(8'h00);
    h.tags_seen = 2'h1;
    h.tag1_tpid = 16'h88a8;
    go(8'h00);
    wr(`ADDR_FLOW_BASE, w0f(4'h1, 2'h1, 4'h9, 2'h0, 2'h0, 3'h1));
    go(8'h01);
    wr(`ADDR_TPID, 32'h9100);
    go(8'h00);
    h.tag1_tpid = 16'h9100;
    go(8'h01);
    wr(`ADDR_TPID, 32'h88a8);
    cfg(w0f(4'h1, 2'h2, 4'ha, 2'h0, 2'h0, 3'h1), {48'h123fff456fff, 24'h0});
    hbase();
    h.tags_seen = 2'h2;
    h.tag1_tpid = 16'h8100;
    h.tag1_vid  = 12'h123;
    h.tag2_tpid = 16'h88a8;
    h.tag2_vid  = 12'h456;
    go(8'h01);
    h.tag2_vid = 12'h457;
    go(8'h00);
    h.tag2_vid  = 12'h456;
    h.tag2_tpid = 16'h8100;
    go(8'h00);
    cfg(w0f(4'h1, 2'h1, 4'h0, 2'h0, 2'h0, 3'h1), {24'h123fff, 48'h0});
    h.tags_seen = 2'h1;
    h.tag1_tpid = 16'h1234;
    h.tag1_vid  = 12'h777;
    go(8'h01);
    h.tags_seen = 2'h0;
    go(8'h00);
    $display("test tag values done");
    cfg(w0f(4'h1, 2'h1, 4'h0, 2'h1, 2'h0, 3'h1), {48'h0, 24'h010020});
    h.tags_seen = 2'h1;
    for (k = 0; k < 4; k++)
    begin
      h.tag1_vid = 12'(48'h00f_010_020_021 >> (12 * (3 - k)));
      go(8'((4'b0110 >> k) & 4'h1));
    end
    wr(`ADDR_FLOW_BASE, w0f(4'h1, 2'h2, 4'h0, 2'h2, 2'h0, 3'h1));
    h.tags_seen = 2'h2;
    h.tag1_vid  = 12'h100;
    h.tag2_vid  = 12'h021;
    go(8'h00);
    h.tag2_vid = 12'h015;
    go(8'h01);
    wr(`ADDR_FLOW_BASE, w0f(4'h1, 2'h2, 4'h0, 2'h0, 2'h0, 3'h1));
    h.tag2_vid = 12'h100;
    go(8'h01);
    $display("test tag range done");
    wr(`ADDR_GLOBAL, 32'h1);
    cfg(w0f(4'h1, 2'h2, 4'h0, 2'h1, 2'h0, 3'h1), {48'h0, 24'h456123});
    hbase();
    h.tags_seen = 2'h2;
    h.tag1_tpid = 16'h88a8;
    h.tag1_vid  = 12'hfff;
    h.itag_sid  = 24'h123456;
    go(8'h01);
    h.itag_sid = 24'h123457;
    go(8'h00);
    h.itag_sid = 24'h122456;
    go(8'h00);
    h.itag_sid  = 24'h123456;
    h.tags_seen = 2'h1;
    go(8'h00);
    wr(`ADDR_FLOW_BASE, w0f(4'h1, 2'h2, 4'h2, 2'h1, 2'h0, 3'h1));
    h.tags_seen = 2'h2;
    go(8'h01);
    wr(`ADDR_GLOBAL, 32'h0);
    $display("test backbone done");
    wr(`ADDR_GLOBAL, 32'h2);
    for (k = 0; k < 8; k++)
      wr(`ADDR_FLOW_BASE + 8'(4 * k), w0f(4'h1, 2'h0, 4'h0, 2'h0, 2'h0, 3'h2) | {13'h0, k[0], 18'h0});
    hbase();
    go(8'hff);
    chk({24'h0, result_out.group_b}, 32'h0000_00aa);
    wr(`ADDR_GLOBAL, 32'h0);
    wr(8'h1c, 32'h0);
    go(8'hf7);
    chk({24'h0, result_out.group_b}, 32'h0);
    rd(`ADDR_MATCHED, 32'h0000_00f7);
    $display("test flow groups done");
    wrap_up();
  end
endmodule : ethernet_flow_matcher_tb_top
